/* verilog/acc_pkg.sv */
// Shared constants and types for the converter control block
`default_nettype none
package acc_pkg;

  //////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL  = 8'h1F;
  localparam logic [7:0] IDX_PORT_CFG = 8'h9F;
  localparam logic [7:0] IDX_RES_HIGH = 8'h20;
  localparam logic [7:0] IDX_RES_LOW  = 8'h21;
  localparam logic [7:0] IDX_STATUS   = 8'h22;
  localparam int         ADDR_W       = 12;

  //////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_CS_LSB   = 6;
  localparam int CTRL_CH_LSB   = 3;
  localparam int CTRL_GO_BIT   = 2;
  localparam int CTRL_ON_BIT   = 0;
  localparam int PCFG_JUST_BIT = 7;
  localparam int STAT_DONE_BIT = 0;

  // Reset values
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] PORT_CFG_RST = 8'h00;

  //////////////////////////////////////////////////////////////////////
  // Result width and conversion clock divider terminal counts
  localparam int         RES_BITS   = 10;
  localparam int         JUST_PAD   = 6;
  localparam logic [4:0] DIV2_LAST  = 5'h01;
  localparam logic [4:0] DIV8_LAST  = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1F;

  // Conversion clock select codes
  typedef enum logic [1:0] {
    CS_DIV2  = 2'b00,
    CS_DIV8  = 2'b01,
    CS_DIV32 = 2'b10,
    CS_RC    = 2'b11
  } acc_clksel_t;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    acc_clksel_t clk_sel;
    logic [2:0]  chan;
    logic        go;
    logic        unused;
    logic        power_on;
  } acc_ctrl_t;

  // Successive approximation engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_CONV = 2'b10
  } acc_state_t;

endpackage
`default_nettype wire

/* verilog/acc_sar_engine.sv */
// Successive approximation sequencer, one result bit per conversion period
`timescale 1ns/100ps
`default_nettype none
module acc_sar_engine #(
  parameter int BITS = acc_pkg::RES_BITS
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            start,
  input  wire logic            abort,
  input  wire logic            tad_tick,
  input  wire logic            comp_hi,
  output logic                 busy,
  output logic                 done,
  output logic                 hold,
  output logic [BITS-1:0]      trial,
  output logic [BITS-1:0]      result
);

  localparam int IW = $clog2(BITS);

  acc_pkg::acc_state_t state;
  logic [IW-1:0]       bit_idx;

  //////////////////////////////////////////////////////////////////////
  // Sequencer: hold one period, then decide MSB first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state   <= acc_pkg::ST_IDLE;
      bit_idx <= '0;
      trial   <= '0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        state <= acc_pkg::ST_IDLE;      // Result left untouched
      end else begin
        case (state)
          acc_pkg::ST_IDLE: begin
            if (start) begin
              state <= acc_pkg::ST_HOLD;
              trial <= '0;
            end
          end
          acc_pkg::ST_HOLD: begin
            if (tad_tick) begin
              state            <= acc_pkg::ST_CONV;
              bit_idx          <= IW'(BITS - 1);
              trial[BITS-1]    <= 1'b1;
            end
          end
          acc_pkg::ST_CONV: begin
            if (tad_tick) begin
              trial[bit_idx] <= comp_hi;
              if (bit_idx == '0) begin
                state <= acc_pkg::ST_IDLE;
                done  <= 1'b1;
              end else begin
                bit_idx            <= bit_idx - 1'b1;
                trial[bit_idx - 1'b1] <= 1'b1;
              end
            end
          end
          default: state <= acc_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Final word captured with the last decision
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result <= '0;
    end else if (!abort && state == acc_pkg::ST_CONV && tad_tick && bit_idx == '0) begin
      result <= {trial[BITS-1:1], comp_hi};
    end
  end

  assign busy = (state != acc_pkg::ST_IDLE);
  assign hold = busy;

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_conv_steps: assert property (
    state == acc_pkg::ST_HOLD && tad_tick && !abort |=> trial == {1'b1, {(BITS-1){1'b0}}})
    else $error("first trial is not the MSB");
  a_done_idle: assert property (
    done |-> state == acc_pkg::ST_IDLE && $past(state == acc_pkg::ST_CONV))
    else $error("done without final step");

endmodule
`default_nettype wire

/* verilog/acc_conv_ctrl.sv */
// APB control and sequencing for the successive approximation converter
`timescale 1ns/100ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Five analogue inputs on small variants, eight on large ones.
// - Every conversion yields a 10-bit result.
// - Successive approximation on the held sample, one bit per step.
// - Reference sources chosen by software from rails and two pins.
// - Conversion runs during sleep only on the internal RC clock.
// - Clock select bits 7-6: osc/2, osc/8, osc/32, internal RC.
// - Channel select bits 5-3 pick channel 0..7; 5-7 absent on small parts.
// - With power on, writing go bit 2 starts; reads one while busy.
// - Hardware clears go when the conversion finishes.
// - Power bit 0 runs the converter; clear means shut down.
// - Control bit 1 is unimplemented and reads zero.
// - On completion load result pair, clear go, set done flag.
// - Justify select gives right or left aligned result, padding reads zero.
module acc_conv_ctrl #(
  parameter int NUM_CHAN = 8
) (
  input  wire logic                       CORE_CLK,
  input  wire logic                       RESET_N,
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [acc_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [31:0]                PWDATA,
  output logic [31:0]                     PRDATA,
  output logic                            PREADY,
  output logic                            PSLVERR,
  input  wire logic                       SLEEP,
  input  wire logic                       RC_OSC,
  input  wire logic                       COMP_IN,
  output logic                            ANALOG_POWER,
  output logic                            SAMPLE_HOLD,
  output logic [acc_pkg::RES_BITS-1:0]    DAC_CODE,
  output logic [NUM_CHAN-1:0]             CHANNEL_SEL,
  output logic [3:0]                      REF_CONFIG
);

  acc_pkg::acc_ctrl_t          ctrl;
  logic [7:0]                  port_cfg;
  logic [acc_pkg::RES_BITS-1:0] res;
  logic                        done_flag;
  logic                        rc_s1;
  logic                        rc_s2;
  logic                        rc_s3;
  logic                        rc_edge;
  logic [4:0]                  div_cnt;
  logic [4:0]                  div_last;
  logic                        div_tick;
  logic                        tad_tick;
  logic                        busy;
  logic                        conv_done;
  logic [acc_pkg::RES_BITS-1:0] sar_result;
  logic                        wr_en;
  logic                        setup;
  logic [7:0]                  idx;
  logic                        aligned;
  logic                        hit_ctrl;
  logic                        hit_pcfg;
  logic                        hit_resh;
  logic                        hit_resl;
  logic                        hit_stat;
  logic                        mapped;
  logic [7:0]                  rd_byte;
  logic [7:0]                  res_high;
  logic [7:0]                  res_low;
  logic                        start;
  logic                        abort;
  acc_pkg::acc_ctrl_t          wctrl;

  //////////////////////////////////////////////////////////////////////
  // Address decode; only word aligned indices answer
  assign idx      = PADDR[9:2];
  assign aligned  = (PADDR[1:0] == 2'h0) && (PADDR[acc_pkg::ADDR_W-1:10] == '0);
  assign hit_ctrl = aligned && idx == acc_pkg::IDX_CONTROL;
  assign hit_pcfg = aligned && idx == acc_pkg::IDX_PORT_CFG;
  assign hit_resh = aligned && idx == acc_pkg::IDX_RES_HIGH;
  assign hit_resl = aligned && idx == acc_pkg::IDX_RES_LOW;
  assign hit_stat = aligned && idx == acc_pkg::IDX_STATUS;
  assign mapped   = hit_ctrl | hit_pcfg | hit_resh | hit_resl | hit_stat;
  assign setup    = PSEL && !PENABLE;
  assign wr_en    = PSEL && PENABLE && PWRITE && mapped;
  assign wctrl    = acc_pkg::acc_ctrl_t'(PWDATA[7:0]);

  // Zero wait state: every access completes in its first access cycle
  assign PREADY = PSEL && PENABLE;

  //////////////////////////////////////////////////////////////////////
  // RC input synchroniser; first stage feeds only the second stage
  // The comparator is not synchronised: its answer follows our own DAC_CODE
  // register against a frozen sample, and two extra stages would miss osc/2
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      rc_s1   <= 1'b0;
      rc_s2   <= 1'b0;
      rc_s3   <= 1'b0;
    end else begin
      rc_s1   <= RC_OSC;
      rc_s2   <= rc_s1;
      rc_s3   <= rc_s2;
    end
  end

  // RC oscillator must run well below half the core rate to be seen
  assign rc_edge = rc_s2 && !rc_s3;

  //////////////////////////////////////////////////////////////////////
  // Conversion clock divider from the core oscillator
  always_comb begin
    case (ctrl.clk_sel)
      acc_pkg::CS_DIV2:  div_last = acc_pkg::DIV2_LAST;
      acc_pkg::CS_DIV8:  div_last = acc_pkg::DIV8_LAST;
      acc_pkg::CS_DIV32: div_last = acc_pkg::DIV32_LAST;
      default:           div_last = acc_pkg::DIV32_LAST;
    endcase
  end

  // Divider held at zero while idle so each conversion starts in phase;
  // frozen, not cleared, in sleep so no bit period is lost on wake
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      div_cnt <= '0;
    end else if (!busy) begin
      div_cnt <= '0;
    end else if (!SLEEP) begin
      div_cnt <= (div_cnt >= div_last) ? 5'h00 : div_cnt + 5'h01;
    end
  end

  assign div_tick = busy && !SLEEP && (div_cnt >= div_last);

  // Core oscillator stops in sleep, so only the RC path keeps ticking
  assign tad_tick = ctrl.power_on &&
                    ((ctrl.clk_sel == acc_pkg::CS_RC) ? rc_edge : div_tick);

  //////////////////////////////////////////////////////////////////////
  // Start and abort
  assign start = wr_en && hit_ctrl && wctrl.go && wctrl.power_on && ctrl.power_on && !busy;
  assign abort = busy && !ctrl.power_on;

  acc_sar_engine #(
    .BITS     (acc_pkg::RES_BITS)
  ) u_sar (
    .clk      (CORE_CLK),
    .rst_n    (RESET_N),
    .start    (start),
    .abort    (abort),
    .tad_tick (tad_tick),
    .comp_hi  (COMP_IN),
    .busy     (busy),
    .done     (conv_done),
    .hold     (SAMPLE_HOLD),
    .trial    (DAC_CODE),
    .result   (sar_result)
  );

  //////////////////////////////////////////////////////////////////////
  // Control register; go is not stored, it mirrors the engine
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ctrl <= acc_pkg::acc_ctrl_t'(acc_pkg::CONTROL_RST);
    end else if (wr_en && hit_ctrl) begin
      ctrl.clk_sel  <= wctrl.clk_sel;
      ctrl.chan     <= wctrl.chan;
      ctrl.power_on <= wctrl.power_on;
    end
  end

  // Port configuration: justify select and reference selection
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      port_cfg <= acc_pkg::PORT_CFG_RST;
    end else if (wr_en && hit_pcfg) begin
      port_cfg <= {PWDATA[acc_pkg::PCFG_JUST_BIT], 3'h0, PWDATA[3:0]};
    end
  end

  assign REF_CONFIG   = port_cfg[3:0];
  assign ANALOG_POWER = ctrl.power_on;

  //////////////////////////////////////////////////////////////////////
  // Result pair, loaded only by a finished conversion
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      res <= '0;
    end else if (conv_done) begin
      res <= sar_result;
    end
  end

  // Done flag: software writes zero to clear; a new completion wins
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      done_flag <= 1'b0;
    end else if (conv_done) begin
      done_flag <= 1'b1;
    end else if (wr_en && hit_stat && !PWDATA[acc_pkg::STAT_DONE_BIT]) begin
      done_flag <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Channel select, one enable per implemented input
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
          CHANNEL_SEL[gi] <= 1'b0;
        end else begin
          CHANNEL_SEL[gi] <= ctrl.power_on && (ctrl.chan == 3'(gi));
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Read path; justify choice pads the unused bits with zero
  always_comb begin
    if (port_cfg[acc_pkg::PCFG_JUST_BIT]) begin
      res_high = {{acc_pkg::JUST_PAD{1'b0}}, res[9:8]};
      res_low  = res[7:0];
    end else begin
      res_high = res[9:2];
      res_low  = {res[1:0], {acc_pkg::JUST_PAD{1'b0}}};
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctrl) begin
      rd_byte = {ctrl.clk_sel, ctrl.chan, busy, 1'b0, ctrl.power_on};
    end else if (hit_pcfg) begin
      rd_byte = port_cfg;
    end else if (hit_resh) begin
      rd_byte = res_high;
    end else if (hit_resl) begin
      rd_byte = res_low;
    end else if (hit_stat) begin
      rd_byte = {7'h00, done_flag};
    end
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA  <= PWRITE ? 32'h00000000 : {24'h000000, rd_byte};
      PSLVERR <= !mapped;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  a_go_starts: assert property (
    start |=> busy && SAMPLE_HOLD)
    else $error("go write did not start a conversion");
  a_go_reads_busy: assert property (
    setup && !PWRITE && hit_ctrl |=> PRDATA[acc_pkg::CTRL_GO_BIT] == $past(busy))
    else $error("go bit does not show conversion state");
  a_done_clears_go: assert property (
    conv_done |-> ##1 !busy && done_flag)
    else $error("completion did not clear go or set flag");
  a_result_load: assert property (
    conv_done |=> res == $past(sar_result))
    else $error("result pair not loaded");
  a_bit1_zero: assert property (
    setup && !PWRITE && hit_ctrl |=> PRDATA[1] == 1'b0)
    else $error("unimplemented control bit reads one");
  a_abort_keeps: assert property (
    abort |=> !busy && $stable(res) && done_flag == $past(done_flag))
    else $error("abort disturbed result or flag");
  a_off_no_tick: assert property (
    !ctrl.power_on |-> !tad_tick && !start)
    else $error("converter ticks while off");
  a_sleep_rc_only: assert property (
    SLEEP && ctrl.clk_sel != acc_pkg::CS_RC |-> !tad_tick)
    else $error("conversion advanced in sleep without RC clock");
  a_div8_period: assert property (
    tad_tick && ctrl.clk_sel == acc_pkg::CS_DIV8 |=> !tad_tick [*7])
    else $error("osc/8 period shorter than eight cycles");
  a_chan_onehot: assert property (
    $onehot0(CHANNEL_SEL))
    else $error("more than one channel selected");
  a_right_justify: assert property (
    setup && !PWRITE && hit_resh && port_cfg[acc_pkg::PCFG_JUST_BIT] |=> PRDATA[7:2] == 6'h00)
    else $error("right justified high byte not padded");

  c_conv_done: cover property (conv_done);
  c_abort: cover property (abort);
  c_sleep_conv: cover property (SLEEP && busy && tad_tick);
  c_left_read: cover property (setup && hit_resl && !port_cfg[acc_pkg::PCFG_JUST_BIT]);

endmodule
`default_nettype wire

/* bench/adc_conversion_control_test.sv */
// Self-checking bench for the converter control block, driven over APB
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_control_test;

  //////////////////////////////////////////////////////////////////////
  // Bench signals
  logic                         core_clk;
  logic                         reset_n;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [acc_pkg::ADDR_W-1:0]   paddr;
  logic [31:0]                  pwdata;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         sleep;
  logic                         rc_osc = 1'b0;
  logic                         comp_in;
  logic                         analog_power;
  logic                         sample_hold;
  logic [acc_pkg::RES_BITS-1:0] dac_code;
  logic [7:0]                   channel_sel;
  logic [3:0]                   ref_config;
  logic [9:0]                   level;
  logic [2:0]                   rc_cnt = 3'h0;
  logic [31:0]                  rdata;
  logic                         last_err;
  int                           n_mismatch;
  int                           checks;
  logic [7:0]                   reg_idx [5];

  acc_conv_ctrl #(.NUM_CHAN(8)) dut_u (
    .CORE_CLK     (core_clk),
    .RESET_N      (reset_n),
    .PSEL         (psel),
    .PENABLE      (penable),
    .PWRITE       (pwrite),
    .PADDR        (paddr),
    .PWDATA       (pwdata),
    .PRDATA       (prdata),
    .PREADY       (pready),
    .PSLVERR      (pslverr),
    .SLEEP        (sleep),
    .RC_OSC       (rc_osc),
    .COMP_IN      (comp_in),
    .ANALOG_POWER (analog_power),
    .SAMPLE_HOLD  (sample_hold),
    .DAC_CODE     (dac_code),
    .CHANNEL_SEL  (channel_sel),
    .REF_CONFIG   (ref_config)
  );

  //////////////////////////////////////////////////////////////////////
  // Clock, RC oscillator at one eighth of the core rate, comparator
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    rc_cnt <= rc_cnt + 3'h1;
    rc_osc <= rc_cnt[2];
  end

  // Analogue comparator responds at once, so no extra latency is modelled
  assign comp_in = (level >= dac_code);

  //////////////////////////////////////////////////////////////////////
  // Comparison, closing and one APB transfer
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Request held until pready is seen high, then released
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] data);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rdata    = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////
  // Conversion helpers
  task automatic start_conv(input logic [1:0] cs, input logic [2:0] ch, input logic [9:0] lvl, input logic just);
    level <= lvl;
    apb(1'b1, acc_pkg::IDX_PORT_CFG, {24'h0, just, 7'h00});
    apb(1'b1, acc_pkg::IDX_CONTROL, {24'h0, cs, ch, 3'b001});
    apb(1'b1, acc_pkg::IDX_CONTROL, {24'h0, cs, ch, 3'b101});
    check("channel select", {24'h0, channel_sel}, 32'h1 << ch);
    apb(1'b0, acc_pkg::IDX_CONTROL, 32'h0);
    check("go while busy", rdata, {24'h0, cs, ch, 3'b101});
    check("sample hold", {31'h0, sample_hold}, 32'h1);
  endtask

  // Polls go under a bounded count; a hang is caught by the watchdog too
  task automatic check_result(input logic [9:0] lvl, input logic just);
    int n;
    n = 0;
    do begin
      apb(1'b0, acc_pkg::IDX_CONTROL, 32'h0);
      n++;
    end while (rdata[2] !== 1'b0 && n < 400);
    check("go cleared", {31'h0, rdata[2]}, 32'h0);
    apb(1'b0, acc_pkg::IDX_RES_HIGH, 32'h0);
    check("result high", rdata, just ? {30'h0, lvl[9:8]} : {24'h0, lvl[9:2]});
    apb(1'b0, acc_pkg::IDX_RES_LOW, 32'h0);
    check("result low", rdata, just ? {24'h0, lvl[7:0]} : {24'h0, lvl[1:0], 6'h00});
    apb(1'b0, acc_pkg::IDX_STATUS, 32'h0);
    check("done flag set", rdata, 32'h1);
    apb(1'b1, acc_pkg::IDX_STATUS, 32'h0);
    apb(1'b0, acc_pkg::IDX_STATUS, 32'h0);
    check("done flag cleared", rdata, 32'h0);
    // Two bit periods of the slowest clock before the next acquisition
    repeat (70) @(posedge core_clk);
  endtask

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_n  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = '0;
    pwdata   = 32'h0;
    sleep    = 1'b0;
    level    = 10'h000;
    checks   = 0;
    n_mismatch = 0;
    reg_idx  = '{acc_pkg::IDX_CONTROL, acc_pkg::IDX_PORT_CFG, acc_pkg::IDX_RES_HIGH,
                 acc_pkg::IDX_RES_LOW, acc_pkg::IDX_STATUS};
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    // Every register starts at zero
    foreach (reg_idx[i]) begin
      apb(1'b0, reg_idx[i], 32'h0);
      check("reset value", rdata, 32'h0);
    end
    // Unmapped place: error response, write dropped, reads zero
    apb(1'b1, 8'h30, 32'hFF);
    check("unmapped write error", {31'h0, last_err}, 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    check("unmapped read", {rdata[30:0], last_err}, 32'h1);
    // Go with power not yet on is ignored; bit 1 always reads zero
    apb(1'b1, acc_pkg::IDX_CONTROL, 32'hFF);
    apb(1'b0, acc_pkg::IDX_CONTROL, 32'h0);
    check("control power up", rdata, 32'hF9);
    check("analog power on", {31'h0, analog_power}, 32'h1);
    apb(1'b1, acc_pkg::IDX_PORT_CFG, 32'hFA);
    apb(1'b0, acc_pkg::IDX_PORT_CFG, 32'h0);
    check("port config", rdata, 32'h8A);
    check("reference select", {28'h0, ref_config}, 32'hA);
    // One conversion for each clock select, boundary levels, both alignments
    start_conv(2'b00, 3'd0, 10'h3FF, 1'b1);
    check_result(10'h3FF, 1'b1);
    // Mixed bits at the fastest clock: each decision must see its own trial
    start_conv(2'b00, 3'd1, 10'h156, 1'b0);
    check_result(10'h156, 1'b0);
    start_conv(2'b01, 3'd3, 10'h000, 1'b0);
    check_result(10'h000, 1'b0);
    start_conv(2'b10, 3'd5, 10'h2A5, 1'b1);
    check_result(10'h2A5, 1'b1);
    start_conv(2'b11, 3'd7, 10'h15A, 1'b0);
    check_result(10'h15A, 1'b0);
    // Sleep freezes a divided-clock conversion without aborting it
    start_conv(2'b01, 3'd2, 10'h1C3, 1'b1);
    sleep <= 1'b1;
    repeat (300) @(posedge core_clk);
    apb(1'b0, acc_pkg::IDX_CONTROL, 32'h0);
    check("go during sleep", {31'h0, rdata[2]}, 32'h1);
    sleep <= 1'b0;
    check_result(10'h1C3, 1'b1);
    // On the internal RC clock the conversion runs to the end in sleep
    start_conv(2'b11, 3'd4, 10'h0F0, 1'b0);
    sleep <= 1'b1;
    check_result(10'h0F0, 1'b0);
    sleep <= 1'b0;
    // Power off mid-conversion aborts; result and done flag stay
    start_conv(2'b10, 3'd6, 10'h3C3, 1'b0);
    repeat (60) @(posedge core_clk);
    apb(1'b1, acc_pkg::IDX_CONTROL, {24'h0, 2'b10, 3'd6, 3'b000});
    apb(1'b0, acc_pkg::IDX_CONTROL, 32'h0);
    check("control after abort", rdata, {24'h0, 2'b10, 3'd6, 3'b000});
    apb(1'b0, acc_pkg::IDX_STATUS, 32'h0);
    check("done flag after abort", rdata, 32'h0);
    apb(1'b0, acc_pkg::IDX_RES_HIGH, 32'h0);
    check("result kept", rdata, 32'h3C);
    check("analog power off", {31'h0, analog_power}, 32'h0);
    check("channels off", {24'h0, channel_sel}, 32'h0);
    check("hold released", {31'h0, sample_hold}, 32'h0);
    test_done();
  end

  // Watchdog well beyond the few thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end

endmodule
`default_nettype wire
